// ===== ecd_pkg.sv
// Constants shared by the extended instruction decoder files.
// Assumes a 20 MHz hclk and a single AHB-Lite master.
`default_nettype none
package ecd_pkg;
   // ==========================================
   // Widths
   localparam int AW = 12;
   localparam int PCW = 21;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] R_CTRL = 8'h00;
   localparam logic [7:0] R_INSTR = 8'h04;
   localparam logic [7:0] R_WORKING_REGISTER = 8'h08;
   localparam logic [7:0] R_BSR = 8'h0C;
   localparam logic [7:0] R_PC = 8'h10;
   localparam logic [7:0] R_STAT = 8'h14;
   localparam logic [7:0] R_FSR0 = 8'h18;
   localparam logic [7:0] R_FSR1 = 8'h1C;
   localparam logic [7:0] R_THIRD_FILE_POINTER = 8'h20;
   localparam logic [7:0] R_TOS = 8'h24;
   localparam logic [7:0] R_TABLE_POINTER = 8'h28;
   localparam logic [7:0] R_TABLE_LATCH_BYTE = 8'h2C;
   localparam logic [7:0] R_HOLD = 8'h30;
   localparam logic [7:0] R_PCLAT = 8'h34;
   localparam logic [7:0] R_MADDR = 8'h38;
   localparam logic [7:0] R_MDATA = 8'h3C;
   localparam logic [7:0] R_CYC = 8'h40;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ==========================================
   // Field positions
   localparam int CTRL_EXT = 0;
   localparam int ST_N = 0;
   localparam int ST_Z = 1;
   localparam int ST_SKIP = 2;
   localparam int ST_BUSY = 3;
   // ==========================================
   // Opcode patterns
   localparam logic [7:0] OP_XOR_LITERAL_OP = 8'h0A;
   localparam logic [5:0] OP_XOR_REGISTER_OP = 6'h06;
   localparam logic [6:0] OP_TST = 7'h33;
   localparam logic [13:0] OP_TABLE_WRITE_OP = 14'h0003;
   localparam logic [15:0] OP_REGISTER_CALL_OP = 16'h0014;
   localparam logic [7:0] OP_POINTER_ADD_OP = 8'hE8;
   localparam logic [7:0] OP_POINTER_SUB_OP = 8'hE9;
   localparam logic [7:0] OP_LITERAL_PUSH_OP = 8'hEA;
   localparam logic [7:0] OP_MOVS = 8'hEB;
   localparam logic [3:0] OP_SECOND = 4'hF;
   localparam logic [3:0] OP_MOVFF = 4'hC;
   localparam logic [6:0] OP_CALL = 7'h76;
   localparam logic [7:0] OP_LFSR = 8'hEE;
   localparam logic [7:0] OP_GOTO = 8'hEF;
   localparam logic [1:0] FF_THIRD = 2'h3;
   // ==========================================
   // Data space landmarks
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_LOW = 4'h0;
   localparam logic [3:0] ACC_HIGH = 4'hF;
   localparam logic [11:0] A_PCL = 12'hFF9;
   localparam logic [11:0] A_TOSL = 12'hFFD;
   localparam logic [11:0] A_TOSH = 12'hFFE;
   localparam logic [11:0] A_TOSU = 12'hFFF;
   localparam logic [11:0] A_IND0 = 12'hFEB;
   localparam logic [11:0] A_IND1 = 12'hFE3;
   localparam logic [11:0] A_IND2 = 12'hFDB;
   localparam logic [11:0] IND_SPAN = 12'h005;
   // ==========================================
   // Steps and cycle figures
   localparam logic [PCW-1:0] PC_STEP = 21'h00_0002;
   localparam logic [PCW-1:0] TP_STEP = 21'h00_0001;
   localparam logic [31:0] CYC_ONE = 32'h0000_0001;
   localparam logic [31:0] CYC_TWO = 32'h0000_0002;
   localparam logic [5:0] DEC_ONE = 6'h01;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RD = 2'b01,
      S_EX = 2'b10,
      S_WR = 2'b11
   } ecd_state_e;
endpackage
`default_nettype wire

// ===== ecd_mem.sv
// Byte-wide data memory with registered read data.
// Assumes one access per cycle, write and read share the address.
`default_nettype none
module ecd_mem #(
   parameter int AW = 12,
   parameter int DEPTH = 4096
) (
   input wire logic hclk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];
   generate
      if (DEPTH < (1 << AW)) begin : g_chk
         $error("ecd_mem depth too small");
      end
   endgenerate
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// ===== ecd_ptr.sv
// One file select pointer: load, add or subtract a literal.
// Assumes at most one of the controls is high in a cycle.
`default_nettype none
module ecd_ptr #(
   parameter int W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ld,
   input wire logic [W-1:0] ld_val,
   input wire logic add,
   input wire logic sub,
   input wire logic [5:0] k,
   output logic [W-1:0] q
);
   generate
      if (W < 7) begin : g_chk
         $error("ecd_ptr width too small");
      end
   endgenerate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else if (ld) begin
         q <= ld_val;
      end else if (add) begin
         q <= q + W'(k);
      end else if (sub) begin
         q <= q - W'(k);
      end
   end
endmodule
`default_nettype wire

// ===== ecd_core.sv
// Extended instruction decode and execute, reached over AHB-Lite.
// Assumes words arrive one by one via the instruction register.
//
// Our own choices: register access over AHB-Lite and the address map.
`default_nettype none
module ecd_core
   import ecd_pkg::*;
#(
   parameter int MEM_DEPTH = 4096
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   // ==========================================
   // Bus slave
   logic dp_v, dp_w, rd_done;
   logic [7:0] dp_a;
   ecd_state_e st;
   logic busy, wr_acc, issue;
   assign busy = (st != S_IDLE);
   assign hreadyout = !dp_v || (!busy && (dp_w || rd_done));
   assign hresp = 1'b0;
   assign wr_acc = dp_v && dp_w && hreadyout;
   assign issue = wr_acc && (dp_a == R_INSTR);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_v <= 1'b0;
         dp_w <= 1'b0;
         dp_a <= '0;
      end else if (hready) begin
         dp_v <= hsel && htrans[1] && (haddr[31:8] == '0);
         dp_w <= hwrite && (hsize == HSIZE_WORD);
         dp_a <= haddr[7:0];
      end
   end
   // Reads take one wait so the data leave a flip-flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done <= 1'b0;
      end else begin
         rd_done <= dp_v && !dp_w && !rd_done && !busy;
      end
   end
   // ==========================================
   // Architectural state
   logic ext_en, flag_n, flag_z, skip_pend, skip_second;
   logic mv_pend, mv_idx, src_ind, cur_d;
   logic [7:0] working_register, pc_high_latch, pc_upper_latch, table_latch_byte, mv_data;
   logic [3:0] bank_select_register;
   logic [PCW-1:0] pc, top_of_return_stack, table_pointer;
   logic [AW-1:0] maddr, op_addr;
   logic [31:0] cyc;
   logic [15:0] cur;
   logic [7:0] hold [8];
   logic [AW-1:0] file_select_pointer [3];
   logic [7:0] mem_rdata;
   // ==========================================
   // Decode of the word being issued
   logic [15:0] iw;
   logic [7:0] op8, lit;
   logic [1:0] ff;
   logic [5:0] k6;
   logic plain, two_word, is_xor_literal_op, is_xor_register_op, is_tst, is_table_write_op;
   logic is_register_call_op, is_addf, is_subf, is_literal_push_op, is_movs, dest_bad;
   logic [AW-1:0] fa, idx_src, dest;
   assign iw = hwdata[15:0];
   assign op8 = iw[15:8];
   assign lit = iw[7:0];
   assign ff = iw[7:6];
   assign k6 = iw[5:0];
   assign plain = !skip_pend && !skip_second && !mv_pend;
   assign is_xor_literal_op = (op8 == OP_XOR_LITERAL_OP);
   assign is_xor_register_op = (iw[15:10] == OP_XOR_REGISTER_OP);
   assign is_tst = (iw[15:9] == OP_TST);
   assign is_table_write_op = (iw[15:2] == OP_TABLE_WRITE_OP);
   assign is_register_call_op = ext_en && (iw == OP_REGISTER_CALL_OP);
   assign is_addf = ext_en && (op8 == OP_POINTER_ADD_OP);
   assign is_subf = ext_en && (op8 == OP_POINTER_SUB_OP);
   assign is_literal_push_op = ext_en && (op8 == OP_LITERAL_PUSH_OP);
   assign is_movs = ext_en && (op8 == OP_MOVS);
   assign two_word = (iw[15:12] == OP_MOVFF) || (iw[15:9] == OP_CALL)
      || (op8 == OP_LFSR) || (op8 == OP_GOTO) || is_movs;
   always_comb begin
      if (iw[8]) begin
         fa = {bank_select_register, lit};
      end else if (ext_en && (lit < ACC_SPLIT)) begin
         fa = file_select_pointer[2] + {4'h0, lit};
      end else if (lit < ACC_SPLIT) begin
         fa = {ACC_LOW, lit};
      end else begin
         fa = {ACC_HIGH, lit};
      end
   end
   function automatic logic indirect(input logic [AW-1:0] a);
      indirect = ((a >= A_IND0) && (a < A_IND0 + IND_SPAN))
         || ((a >= A_IND1) && (a < A_IND1 + IND_SPAN))
         || ((a >= A_IND2) && (a < A_IND2 + IND_SPAN));
   endfunction
   assign idx_src = file_select_pointer[2] + {5'h00, iw[6:0]};
   assign dest = mv_idx ? idx_src : iw[11:0];
   assign dest_bad = (dest == A_PCL) || (dest == A_TOSL) || (dest == A_TOSH)
      || (dest == A_TOSU) || (mv_idx && indirect(dest))
      || (iw[15:12] != OP_SECOND);
   // ==========================================
   // Sequencer
   logic start_rd;
   assign start_rd = issue && plain && (is_xor_register_op || is_tst || is_movs);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= S_IDLE;
         op_addr <= '0;
         cur <= '0;
         mv_data <= '0;
         cur_d <= 1'b0;
      end else begin
         case (st)
            S_IDLE: begin
               if (start_rd) begin
                  st <= S_RD;
                  cur <= iw;
                  cur_d <= iw[9];
                  op_addr <= is_movs ? idx_src : fa;
               end else if (issue && plain && is_literal_push_op) begin
                  st <= S_WR;
                  op_addr <= file_select_pointer[2];
                  mv_data <= lit;
               end else if (issue && mv_pend && !dest_bad) begin
                  st <= S_WR;
                  op_addr <= dest;
               end
            end
            S_RD: st <= S_EX;
            S_EX: begin
               if (cur[15:10] == OP_XOR_REGISTER_OP && cur_d) begin
                  st <= S_WR;
                  mv_data <= working_register ^ mem_rdata;
               end else begin
                  st <= S_IDLE;
                  mv_data <= src_ind ? 8'h00 : mem_rdata;
               end
            end
            S_WR: st <= S_IDLE;
            default: st <= S_IDLE;
         endcase
      end
   end
   // ==========================================
   // Skip and two-word tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         skip_pend <= 1'b0;
         skip_second <= 1'b0;
         mv_pend <= 1'b0;
         mv_idx <= 1'b0;
         src_ind <= 1'b0;
      end else begin
         if (st == S_EX && cur[15:9] == OP_TST && mem_rdata == 8'h00) begin
            skip_pend <= 1'b1;
         end else if (issue && skip_pend) begin
            skip_pend <= 1'b0;
            skip_second <= two_word;
         end else if (issue && skip_second) begin
            skip_second <= 1'b0;
         end
         if (st == S_EX && cur[15:8] == OP_MOVS) begin
            mv_pend <= 1'b1;
         end else if (issue && mv_pend) begin
            mv_pend <= 1'b0;
         end
         if (start_rd && is_movs) begin
            mv_idx <= iw[7];
            src_ind <= indirect(idx_src);
         end
      end
   end
   // ==========================================
   // Working register, flags, program counter, return stack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         working_register <= '0;
         flag_n <= 1'b0;
         flag_z <= 1'b0;
      end else if (wr_acc && dp_a == R_WORKING_REGISTER) begin
         working_register <= hwdata[7:0];
      end else if (issue && plain && is_xor_literal_op) begin
         working_register <= working_register ^ lit;
         flag_n <= working_register[7] ^ lit[7];
         flag_z <= (working_register ^ lit) == 8'h00;
      end else if (st == S_EX && cur[15:10] == OP_XOR_REGISTER_OP) begin
         if (!cur_d) begin
            working_register <= working_register ^ mem_rdata;
         end
         flag_n <= working_register[7] ^ mem_rdata[7];
         flag_z <= (working_register ^ mem_rdata) == 8'h00;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc <= '0;
         top_of_return_stack <= '0;
      end else if (wr_acc && dp_a == R_TOS) begin
         top_of_return_stack <= hwdata[PCW-1:0];
      end else if (issue && plain && is_register_call_op) begin
         top_of_return_stack <= pc + PC_STEP;
         pc <= {pc_upper_latch[4:0], pc_high_latch, working_register};
      end else if (issue && plain && (is_addf || is_subf) && ff == FF_THIRD) begin
         pc <= top_of_return_stack;
      end else if (issue) begin
         pc <= pc + PC_STEP;
      end
   end
   // ==========================================
   // Software-held registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_en <= 1'b0;
         bank_select_register <= '0;
         pc_high_latch <= '0;
         pc_upper_latch <= '0;
         table_latch_byte <= '0;
         maddr <= '0;
      end else if (wr_acc) begin
         if (dp_a == R_CTRL) ext_en <= hwdata[CTRL_EXT];
         if (dp_a == R_BSR) bank_select_register <= hwdata[3:0];
         if (dp_a == R_PCLAT) begin
            pc_high_latch <= hwdata[7:0];
            pc_upper_latch <= hwdata[15:8];
         end
         if (dp_a == R_TABLE_LATCH_BYTE) table_latch_byte <= hwdata[7:0];
         if (dp_a == R_MADDR) maddr <= hwdata[AW-1:0];
      end
   end
   // ==========================================
   // Table write
   logic [2:0] hsel_idx;
   assign hsel_idx = (iw[1:0] == 2'h3) ? 3'(table_pointer[2:0] + 3'h1) : table_pointer[2:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         table_pointer <= '0;
         for (int i = 0; i < 8; i++) hold[i] <= '0;
      end else if (wr_acc && dp_a == R_TABLE_POINTER) begin
         table_pointer <= hwdata[PCW-1:0];
      end else if (issue && plain && is_table_write_op) begin
         hold[hsel_idx] <= table_latch_byte;
         if (iw[1:0] == 2'h1 || iw[1:0] == 2'h3) table_pointer <= table_pointer + TP_STEP;
         if (iw[1:0] == 2'h2) table_pointer <= table_pointer - TP_STEP;
      end
   end
   // ==========================================
   // Cycle tally
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc <= '0;
      end else if (issue) begin
         if (plain && (is_register_call_op || is_table_write_op
               || ((is_addf || is_subf) && ff == FF_THIRD))) begin
            cyc <= cyc + CYC_TWO;
         end else begin
            cyc <= cyc + CYC_ONE;
         end
      end
   end
   // ==========================================
   // Pointers and memory
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_fsr
         logic ld, add, sub, pick;
         assign pick = (ff == 2'(gi)) || (gi == 2 && ff == FF_THIRD);
         assign ld = wr_acc && (dp_a == R_FSR0 + 8'(4 * gi));
         assign add = issue && plain && is_addf && pick;
         assign sub = issue && plain && ((is_subf && pick) || (gi == 2 && is_literal_push_op));
         ecd_ptr #(.W(AW)) u_ptr (
            .hclk(hclk),
            .hresetn(hresetn),
            .ld(ld),
            .ld_val(hwdata[AW-1:0]),
            .add(add),
            .sub(sub),
            .k(is_literal_push_op ? DEC_ONE : k6),
            .q(file_select_pointer[gi])
         );
      end
   endgenerate
   logic mem_we;
   assign mem_we = (st == S_WR) || (wr_acc && dp_a == R_MDATA);
   ecd_mem #(.AW(AW), .DEPTH(MEM_DEPTH)) u_mem (
      .hclk(hclk),
      .we(mem_we),
      .addr(busy ? op_addr : maddr),
      .wdata(busy ? mv_data : hwdata[7:0]),
      .rdata(mem_rdata)
   );
   // ==========================================
   // Read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (dp_v && !dp_w && !rd_done && !busy) begin
         if (dp_a == R_CTRL) hrdata <= 32'(ext_en);
         else if (dp_a == R_WORKING_REGISTER) hrdata <= 32'(working_register);
         else if (dp_a == R_BSR) hrdata <= 32'(bank_select_register);
         else if (dp_a == R_PC) hrdata <= 32'(pc);
         else if (dp_a == R_STAT) hrdata <= 32'({busy, skip_pend, flag_z, flag_n});
         else if (dp_a == R_FSR0) hrdata <= 32'(file_select_pointer[0]);
         else if (dp_a == R_FSR1) hrdata <= 32'(file_select_pointer[1]);
         else if (dp_a == R_THIRD_FILE_POINTER) hrdata <= 32'(file_select_pointer[2]);
         else if (dp_a == R_TOS) hrdata <= 32'(top_of_return_stack);
         else if (dp_a == R_TABLE_POINTER) hrdata <= 32'(table_pointer);
         else if (dp_a == R_TABLE_LATCH_BYTE) hrdata <= 32'(table_latch_byte);
         else if (dp_a == R_HOLD) hrdata <= 32'(hold[table_pointer[2:0]]);
         else if (dp_a == R_PCLAT) hrdata <= 32'({pc_upper_latch, pc_high_latch});
         else if (dp_a == R_MADDR) hrdata <= 32'(maddr);
         else if (dp_a == R_MDATA) hrdata <= 32'(mem_rdata);
         else if (dp_a == R_CYC) hrdata <= cyc;
         else hrdata <= '0;
      end
   end
   // ==========================================
   // Checks
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [AW-1:0] fsr0, third_file_pointer;
   assign fsr0 = file_select_pointer[0];
   assign third_file_pointer = file_select_pointer[2];
   a_xor_literal_op_working_register: assert property (issue && plain && is_xor_literal_op
      |=> working_register == ($past(working_register) ^ $past(lit))) else $error("xor literal wrong");
   a_xor_flags: assert property (issue && plain && is_xor_literal_op
      |=> flag_z == (working_register == 8'h00) && flag_n == working_register[7]) else $error("xor flags wrong");
   a_xor_register_op_dest: assert property (st == S_EX && cur[15:10] == OP_XOR_REGISTER_OP && cur_d
      |=> st == S_WR && mem_we ##1 st == S_IDLE) else $error("xor register path wrong");
   a_tst_skip: assert property (st == S_EX && cur[15:9] == OP_TST && mem_rdata == 8'h00
      |=> skip_pend) else $error("skip not armed");
   a_skip_one: assert property (issue && skip_pend && !two_word
      |=> !skip_pend && !skip_second && cyc == $past(cyc) + CYC_ONE)
      else $error("skip length wrong");
   a_ext_off: assert property (issue && !ext_en && op8 == OP_LITERAL_PUSH_OP
      |=> third_file_pointer == $past(third_file_pointer) && st == S_IDLE) else $error("extended op ran disabled");
   a_fsr_add: assert property (issue && plain && is_addf && ff == 2'h0
      |=> fsr0 == $past(fsr0) + AW'($past(k6)) && $stable(flag_z))
      else $error("pointer add wrong");
   a_ulnk_ret: assert property (issue && plain && is_subf && ff == FF_THIRD
      |=> pc == $past(top_of_return_stack) && third_file_pointer == $past(third_file_pointer) - AW'($past(k6)))
      else $error("sub-return wrong");
   a_register_call_op_jump: assert property (issue && plain && is_register_call_op
      |=> pc == {$past(pc_upper_latch[4:0]), $past(pc_high_latch), $past(working_register)}
      && top_of_return_stack == $past(pc) + PC_STEP) else $error("register call wrong");
   a_push_store: assert property (issue && plain && is_literal_push_op
      |=> st == S_WR && op_addr == $past(third_file_pointer) && third_file_pointer == $past(third_file_pointer) - AW'(DEC_ONE))
      else $error("push wrong");
   a_move_reject: assert property (issue && mv_pend && dest_bad
      |=> st == S_IDLE && !mem_we) else $error("bad destination written");
   c_skip: cover property (issue && skip_pend && two_word ##[1:20] issue && skip_second);
   c_ulnk: cover property (issue && plain && is_addf && ff == FF_THIRD);
   c_indexed_to_indexed_move: cover property (st == S_WR && mv_idx ##1 st == S_IDLE);
endmodule
`default_nettype wire

// ===== ecd_ram_model.sv
// Partner model of the core data memory, byte wide.
// Assumes the bench mirrors every store that the core makes.
`default_nettype none
module ecd_ram_model;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Storage
   logic [7:0] m [0:4095];
   initial begin
      foreach (m[i]) m[i] = 8'h00;
   end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the extended instruction decoder.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`default_nettype none
module testbench;
   import ecd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic [31:0] seed = 32'h0000_5c23;
   logic [31:0] q;
   logic [7:0] w, k, v;
   logic [20:0] pc, top_of_return_stack;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   ecd_core i_ecd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   ecd_ram_model i_ecd_ram_model ();
   always #25 hclk = ~hclk;
   // ==========================================
   // Helpers
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask
   task automatic ins(input logic [15:0] op, input int c);
      xfer(1'b1, R_INSTR, {16'h0000, op});
      pc = pc + 21'h2;
      cyc += c;
   endtask
   task automatic rm(input logic [11:0] a);
      xfer(1'b1, R_MADDR, {20'h0_0000, a});
      rc("mem", R_MDATA, {24'h00_0000, i_ecd_ram_model.m[a]});
   endtask
   task automatic stat();
      rc("status", R_STAT, {30'h0, w == 8'h00, w[7]});
   endtask
   task complete_run();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      complete_run();
   end
   // ==========================================
   // Main sequence
   initial begin
      pc = 21'h0;
      w = 8'h00;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc("unmapped", 8'h7C, 32'h0);
      rc("ctrl", R_CTRL, 32'h0);
      xfer(1'b1, R_FSR0, 32'h100);
      ins(16'hE805, 1);
      rc("fsr0 off", R_FSR0, 32'h100);
      ins({OP_LITERAL_PUSH_OP, 8'h12}, 1);
      rc("third_file_pointer off", R_THIRD_FILE_POINTER, 32'h0);
      xfer(1'b1, R_CTRL, 32'h1);
      for (int i = 0; i < 5; i++) begin
         k = (i == 4) ? w : rnd();
         ins({OP_XOR_LITERAL_OP, k}, 1);
         w = w ^ k;
         rc("working_register", R_WORKING_REGISTER, {24'h0, w});
         stat();
      end
      k = rnd();
      ins({8'hE8, 2'b00, k[5:0]}, 1);
      rc("fsr0", R_FSR0, 32'h100 + k[5:0]);
      xfer(1'b1, R_FSR1, 32'h80);
      ins({8'hE9, 2'b01, k[5:0]}, 1);
      rc("fsr1", R_FSR1, 32'h80 - k[5:0]);
      v = rnd() | 8'h01;
      w = rnd();
      xfer(1'b1, R_WORKING_REGISTER, {24'h0, w});
      xfer(1'b1, R_BSR, 32'h2);
      xfer(1'b1, R_MADDR, 32'h2A5);
      xfer(1'b1, R_MDATA, {24'h0, v});
      ins(16'h1BA5, 1);
      i_ecd_ram_model.m[12'h2A5] = v ^ w;
      rm(12'h2A5);
      rc("working_register kept", R_WORKING_REGISTER, {24'h0, w});
      w = v ^ w;
      stat();
      w = v ^ i_ecd_ram_model.m[12'h2A5];
      // skip over one word, then a two-word one
      xfer(1'b1, R_MADDR, 32'h2A6);
      xfer(1'b1, R_MDATA, 32'h0);
      ins(16'h67A6, 1);
      ins(16'h0AFF, 1);
      ins(16'h67A6, 1);
      ins(16'hC000, 1);
      ins(16'hF000, 1);
      rc("working_register skip", R_WORKING_REGISTER, {24'h0, w});
      rc("cycles", R_CYC, cyc);
      k = rnd();
      xfer(1'b1, R_THIRD_FILE_POINTER, 32'h150);
      ins({OP_LITERAL_PUSH_OP, k}, 1);
      i_ecd_ram_model.m[12'h150] = k;
      rm(12'h150);
      rc("third_file_pointer push", R_THIRD_FILE_POINTER, 32'h14F);
      // indexed low access, result to working register
      ins(16'h1801, 1);
      w = w ^ k;
      rc("working_register idx", R_WORKING_REGISTER, {24'h0, w});
      ins(16'hEB81, 1);
      ins(16'hF003, 1);
      i_ecd_ram_model.m[12'h152] = k;
      rm(12'h152);
      ins(16'hEB01, 1);
      ins(16'hF300, 1);
      i_ecd_ram_model.m[12'h300] = k;
      rm(12'h300);
      ins(16'hEB01, 1);
      ins({OP_SECOND, A_PCL}, 1);
      rc("pc", R_PC, pc);
      xfer(1'b1, R_WORKING_REGISTER, 32'h06);
      xfer(1'b1, R_PCLAT, 32'h0010);
      top_of_return_stack = pc + 21'h2;
      ins(OP_REGISTER_CALL_OP, 2);
      pc = 21'h00_1006;
      rc("pc call", R_PC, pc);
      rc("tos", R_TOS, top_of_return_stack);
      stat();
      ins({8'hE8, 2'b11, k[5:0]}, 2);
      pc = top_of_return_stack;
      rc("pc ret", R_PC, pc);
      rc("third_file_pointer add", R_THIRD_FILE_POINTER, 32'h14F + k[5:0]);
      xfer(1'b1, R_TOS, 32'h200);
      ins({8'hE9, 2'b11, k[5:0]}, 2);
      pc = 21'h200;
      rc("pc ret2", R_PC, pc);
      rc("third_file_pointer sub", R_THIRD_FILE_POINTER, 32'h14F);
      // post and pre increment table writes
      xfer(1'b1, R_TABLE_POINTER, 32'h00A356);
      xfer(1'b1, R_TABLE_LATCH_BYTE, 32'h55);
      ins(16'h000D, 2);
      rc("table_pointer", R_TABLE_POINTER, 32'h00A357);
      xfer(1'b1, R_TABLE_POINTER, 32'h00A356);
      rc("hold", R_HOLD, 32'h55);
      xfer(1'b1, R_TABLE_POINTER, 32'h01389A);
      xfer(1'b1, R_TABLE_LATCH_BYTE, 32'h34);
      ins(16'h000F, 2);
      rc("table_pointer pre", R_TABLE_POINTER, 32'h01389B);
      rc("hold pre", R_HOLD, 32'h34);
      rc("cycles end", R_CYC, cyc);
      complete_run();
   end
endmodule
`default_nettype wire
